// >>> hdl/eodrl_bin_sel.v
// bin selector: first of eight increasing boundaries above a value
`timescale 1ns/10ps
`default_nettype none
module eodrl_bin_sel #(
  parameter N_BIN = 8,
  parameter W     = 8
) (
  // boundaries, entry 0 in the low bits
  input  wire [N_BIN*W-1:0] i_bounds,
  // measured value in boundary coding
  input  wire [W-1:0]       i_value,
  // selected bin
  output reg  [2:0]         o_bin
);
  wire [N_BIN-1:0] above;
  integer          k;

  // one compare per boundary
  genvar g;
  generate
    for (g = 0; g < N_BIN; g = g + 1) begin : g_cmp
      assign above[g] = i_bounds[g*W +: W] > i_value;
    end
  endgenerate

  // lowest exceeding boundary wins, last bin when none does
  always @* begin
    o_bin = 3'h7;
    for (k = N_BIN - 1; k >= 0; k = k - 1) begin
      if (above[k]) begin
        o_bin = k[2:0];
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/eodrl_core.v
// end-of-discharge detection, capacity relearn and charge scaling
//
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "eodrl_regs.vh"
module eodrl_core (
  // clock and reset
  input  wire        i_clk_sys,
  input  wire        i_reset,
  // wishbone slave
  input  wire        i_wb_cyc,
  input  wire        i_wb_stb,
  input  wire        i_wb_we,
  input  wire [7:0]  i_wb_adr,
  input  wire [3:0]  i_wb_sel,
  input  wire [31:0] i_wb_dat,
  output reg  [31:0] o_wb_dat,
  output reg         o_wb_ack,
  // measurement front end, same clock
  input  wire        i_period_tick,
  input  wire [15:0] i_pack_mv,
  input  wire [7:0]  i_temp_code,
  input  wire [7:0]  i_temp_deg,
  input  wire [7:0]  i_rate_code,
  input  wire        i_discharging,
  input  wire [15:0] i_dis_cap,
  input  wire [15:0] i_err_inc,
  // charge-end events, one-cycle pulses
  input  wire        i_full_eoc,
  input  wire        i_partial_chg,
  // gauge results
  output wire [15:0] o_batt_status,
  output wire        o_alarm_warn,
  output reg         o_eod_valid,
  output reg  [15:0] o_full_cap,
  output reg  [15:0] o_max_error,
  output reg  [7:0]  o_relative_charge_level,
  output reg  [15:0] o_remaining_amount
);
  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  reg  [7:0]  cfg [0:`EODRL_CFG_N-1];
  reg  [7:0]  eod_confirm_count;
  reg  [7:0]  relearn_rate_limit;
  reg  [15:0] cap_level;
  reg  [15:0] time_level;
  reg  [15:0] learned_full_capacity;
  reg  [15:0] hold_credit;
  reg  [15:0] dis_acc;
  reg  [15:0] thr_mv;
  reg  [2:0]  tbin_q;
  reg  [2:0]  rbin_q;
  reg  [7:0]  low_run;
  reg  [7:0]  last_deg;
  reg         full_seen;
  reg         partial_seen;
  reg         eod_done;
  reg         discharge_end_alarm;
  reg         rem_cap_alarm;
  reg         rem_time_alarm;
  reg  [15:0] next_remaining;
  reg  [15:0] next_credit;
  reg  [16:0] tmp;
  reg  [16:0] tmp2;
  integer     i;

  // ----------------------------------------------------------------------
  // bin selection and threshold lookup
  // ----------------------------------------------------------------------
  wire [63:0] temp_bnd;
  wire [63:0] rate_bnd;
  wire [2:0]  tbin;
  wire [2:0]  rbin;

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_bnd
      assign temp_bnd[g*8 +: 8] = cfg[`EODRL_CFG_TB + g];
      assign rate_bnd[g*8 +: 8] = cfg[`EODRL_CFG_RB + g];
    end
  endgenerate

  eodrl_bin_sel #(.N_BIN(8), .W(8)) u_tbin (
    .i_bounds (temp_bnd),
    .i_value  (i_temp_code),
    .o_bin    (tbin)
  );

  eodrl_bin_sel #(.N_BIN(8), .W(8)) u_rbin (
    .i_bounds (rate_bnd),
    .i_value  (i_rate_code),
    .o_bin    (rbin)
  );

  // rows are rate bins, columns temperature bins
  wire [6:0]  tab_idx  = `EODRL_CFG_TAB + {1'b0, rbin, tbin};
  wire [7:0]  thr_code = cfg[tab_idx];
  wire [15:0] thr_step = {8'h00, thr_code} * `EODRL_VOLT_STEP;
  wire [15:0] thr_now  = `EODRL_VOLT_BASE + thr_step;
  wire        low_v    = i_pack_mv < thr_now;

  // ----------------------------------------------------------------------
  // residual share and per-degree interpolation
  // ----------------------------------------------------------------------
  wire [6:0]  pct_idx  = `EODRL_CFG_PCT + {4'h0, tbin};
  wire [7:0]  pct_now  = cfg[pct_idx];
  wire [7:0]  pct_cold = (tbin == 3'h0) ? pct_now : cfg[pct_idx - 7'd1];
  wire [7:0]  pct_diff = (pct_cold > pct_now) ? pct_cold - pct_now : 8'h00;
  // bins are ten degrees wide, so a tenth of the step per degree
  wire [15:0] dpct     = {8'h00, pct_diff} * `EODRL_DIV10;
  wire [23:0] corr_p   = learned_full_capacity * dpct[15:8];
  wire [15:0] corr_amt = corr_p[23:8];
  wire [23:0] resid_p  = learned_full_capacity * pct_now;
  wire [15:0] resid    = resid_p[23:8];
  // usable part only, so the count runs out at save to disk
  wire [15:0] usable   = (learned_full_capacity > resid) ?
                         learned_full_capacity - resid : 16'h0000;

  // ----------------------------------------------------------------------
  // end-of-discharge qualification
  // ----------------------------------------------------------------------
  wire [7:0]  conf_need = (eod_confirm_count == 8'h00) ? 8'h01 : eod_confirm_count;
  wire [7:0]  low_inc   = (low_run == 8'hff) ? low_run : low_run + 8'h01;
  wire        eod_hit   = i_period_tick & i_discharging & low_v & ~eod_done &
                          (low_inc >= conf_need);
  wire        rate_ok   = i_rate_code <= relearn_rate_limit;
  wire        relearn   = eod_hit & full_seen & ~partial_seen & rate_ok;
  wire [16:0] new_cap   = {1'b0, dis_acc} + {1'b0, i_dis_cap} + {1'b0, resid};
  wire [15:0] new_lfc   = new_cap[16] ? 16'hffff : new_cap[15:0];
  wire [16:0] err_sum   = {1'b0, o_max_error} + {1'b0, i_err_inc};
  wire [16:0] dis_sum   = {1'b0, dis_acc} + {1'b0, i_dis_cap};
  wire        t_fall    = i_temp_deg < last_deg;
  wire        t_rise    = i_temp_deg > last_deg;
  wire [23:0] time_cmp  = i_rate_code * time_level;

  // ----------------------------------------------------------------------
  // discharge, hold credit and cooling correction for one period
  // ----------------------------------------------------------------------
  always @* begin
    next_remaining = o_remaining_amount;
    next_credit    = hold_credit;
    tmp            = 17'h00000;
    tmp2           = 17'h00000;
    if (i_discharging) begin
      // warming credit is spent before the count moves again
      if (hold_credit >= i_dis_cap) begin
        next_credit = hold_credit - i_dis_cap;
      end else begin
        tmp         = {1'b0, i_dis_cap} - {1'b0, hold_credit};
        next_credit = 16'h0000;
        if (o_remaining_amount > tmp[15:0]) begin
          next_remaining = o_remaining_amount - tmp[15:0];
        end else begin
          next_remaining = 16'h0000;
        end
      end
    end
    if (t_fall) begin
      if (next_remaining > corr_amt) begin
        next_remaining = next_remaining - corr_amt;
      end else begin
        next_remaining = 16'h0000;
      end
    end else if (t_rise && i_discharging) begin
      tmp2        = {1'b0, next_credit} + {1'b0, corr_amt};
      next_credit = tmp2[16] ? 16'hffff : tmp2[15:0];
    end
  end

  // ----------------------------------------------------------------------
  // wishbone decode
  // ----------------------------------------------------------------------
  wire        req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // a write lands at the edge where the master samples ack, while its request still stands
  wire        wr     = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;
  wire        in_cfg = (i_wb_adr >= `EODRL_ADR_CFG_LO) &&
                       (i_wb_adr <= `EODRL_ADR_CFG_HI);
  wire [7:0]  cfg_off = i_wb_adr - `EODRL_ADR_CFG_LO;
  wire [6:0]  cfg_b   = {cfg_off[6:2], 2'b00};

  // configuration bytes, one lane per byte enable
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      for (i = 0; i < `EODRL_CFG_N; i = i + 1) begin
        if (i < `EODRL_CFG_PCT) begin
          cfg[i] <= `EODRL_BND_RST;
        end else if (i < `EODRL_CFG_TAB) begin
          cfg[i] <= `EODRL_PCT_RST;
        end else begin
          cfg[i] <= `EODRL_VEOD_RST;
        end
      end
    end else if (wr && in_cfg) begin
      for (i = 0; i < 4; i = i + 1) begin
        if (i_wb_sel[i]) begin
          cfg[cfg_b + i[6:0]] <= i_wb_dat[i*8 +: 8];
        end
      end
    end
  end

  // answer one cycle after the request, unmapped reads give zero
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h00000000;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= 32'h00000000;
      if (req && !i_wb_we) begin
        if (i_wb_adr == `EODRL_ADR_CTRL) begin
          o_wb_dat <= {16'h0000, relearn_rate_limit, eod_confirm_count};
        end else if (i_wb_adr == `EODRL_ADR_STAT) begin
          o_wb_dat <= {16'h0000, o_batt_status};
        end else if (i_wb_adr == `EODRL_ADR_THR) begin
          o_wb_dat <= {9'h000, rbin_q, 1'b0, tbin_q, thr_mv};
        end else if (i_wb_adr == `EODRL_ADR_LFC) begin
          o_wb_dat <= {16'h0000, learned_full_capacity};
        end else if (i_wb_adr == `EODRL_ADR_MAXE) begin
          o_wb_dat <= {16'h0000, o_max_error};
        end else if (i_wb_adr == `EODRL_ADR_RCL) begin
          o_wb_dat <= {24'h000000, o_relative_charge_level};
        end else if (i_wb_adr == `EODRL_ADR_REM) begin
          o_wb_dat <= {hold_credit, o_remaining_amount};
        end else if (i_wb_adr == `EODRL_ADR_ALM) begin
          o_wb_dat <= {time_level, cap_level};
        end else if (in_cfg) begin
          o_wb_dat <= {cfg[cfg_b + 7'd3], cfg[cfg_b + 7'd2],
                       cfg[cfg_b + 7'd1], cfg[cfg_b]};
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // period processing and software-written control
  // ----------------------------------------------------------------------
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      eod_confirm_count     <= `EODRL_CONF_RST;
      relearn_rate_limit    <= `EODRL_RLIM_RST;
      cap_level             <= 16'h0000;
      time_level            <= 16'h0000;
      learned_full_capacity <= `EODRL_LFC_RST;
      o_full_cap            <= `EODRL_LFC_RST;
      o_max_error           <= 16'h0000;
      o_remaining_amount    <= 16'h0000;
      hold_credit           <= 16'h0000;
      dis_acc               <= 16'h0000;
      thr_mv                <= `EODRL_VOLT_BASE;
      tbin_q                <= 3'h0;
      rbin_q                <= 3'h0;
      low_run               <= 8'h00;
      last_deg              <= 8'h00;
      full_seen             <= 1'b0;
      partial_seen          <= 1'b0;
      eod_done              <= 1'b0;
      discharge_end_alarm   <= 1'b0;
      rem_cap_alarm         <= 1'b0;
      rem_time_alarm        <= 1'b0;
      o_eod_valid           <= 1'b0;
    end else begin
      o_eod_valid <= eod_hit;
      // software control words
      if (wr && i_wb_adr == `EODRL_ADR_CTRL) begin
        if (i_wb_sel[0]) eod_confirm_count  <= i_wb_dat[7:0];
        if (i_wb_sel[1]) relearn_rate_limit <= i_wb_dat[15:8];
      end
      if (wr && i_wb_adr == `EODRL_ADR_ALM) begin
        if (i_wb_sel[0]) cap_level[7:0]   <= i_wb_dat[7:0];
        if (i_wb_sel[1]) cap_level[15:8]  <= i_wb_dat[15:8];
        if (i_wb_sel[2]) time_level[7:0]  <= i_wb_dat[23:16];
        if (i_wb_sel[3]) time_level[15:8] <= i_wb_dat[31:24];
      end
      // a relearn in the same cycle outranks a software seed
      if (relearn) begin
        learned_full_capacity <= new_lfc;
        o_full_cap            <= new_lfc;
      end else if (wr && i_wb_adr == `EODRL_ADR_LFC) begin
        if (i_wb_sel[0]) learned_full_capacity[7:0]  <= i_wb_dat[7:0];
        if (i_wb_sel[1]) learned_full_capacity[15:8] <= i_wb_dat[15:8];
        if (i_wb_sel[0]) o_full_cap[7:0]             <= i_wb_dat[7:0];
        if (i_wb_sel[1]) o_full_cap[15:8]            <= i_wb_dat[15:8];
      end
      // charge-side events; partial charge set wins over the clear
      if (i_full_eoc) begin
        full_seen          <= 1'b1;
        dis_acc            <= 16'h0000;
        hold_credit        <= 16'h0000;
        o_remaining_amount <= usable;
        last_deg           <= i_temp_deg;
      end
      if (i_partial_chg) begin
        partial_seen <= 1'b1;
      end else if (i_full_eoc) begin
        partial_seen <= 1'b0;
      end
      // leaving discharge re-arms detection and drops the alarms
      if (!i_discharging) begin
        eod_done            <= 1'b0;
        low_run             <= 8'h00;
        discharge_end_alarm <= 1'b0;
        rem_cap_alarm       <= 1'b0;
        rem_time_alarm      <= 1'b0;
      end
      if (i_period_tick && !i_full_eoc) begin
        thr_mv <= thr_now;
        tbin_q <= tbin;
        rbin_q <= rbin;
        if (t_fall) begin
          last_deg <= last_deg - 8'h01;
        end else if (t_rise) begin
          last_deg <= last_deg + 8'h01;
        end
        o_remaining_amount <= next_remaining;
        hold_credit        <= next_credit;
        if (i_discharging) begin
          dis_acc <= dis_sum[16] ? 16'hffff : dis_sum[15:0];
          low_run <= low_v ? low_inc : 8'h00;
          // early warnings ahead of the terminate alarm
          rem_cap_alarm  <= next_remaining < cap_level;
          rem_time_alarm <= {8'h00, next_remaining} < time_cmp;
        end
        // error grows each period and saturates
        o_max_error <= err_sum[16] ? 16'hffff : err_sum[15:0];
      end
      if (eod_hit) begin
        eod_done            <= 1'b1;
        discharge_end_alarm <= 1'b1;
        o_max_error         <= 16'h0000;
        o_remaining_amount  <= 16'h0000;
        // a full charge in the same cycle wins over the clear
        if (!i_full_eoc) begin
          full_seen <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // relative charge: remaining * 100 / full, free-running divider
  // ----------------------------------------------------------------------
  reg  [22:0] div_num;
  reg  [16:0] div_r;
  reg  [22:0] div_q;
  reg  [4:0]  div_cnt;
  wire [16:0] div_sh  = {div_r[15:0], div_num[22]};
  wire        div_ge  = div_sh >= {1'b0, learned_full_capacity};
  wire [22:0] rem_x   = o_remaining_amount * `EODRL_PCT_FULL;
  wire [22:0] q_fin   = {div_q[21:0], div_ge};
  wire [22:0] pct_full = `EODRL_PCT_FULL;

  // restart with fresh operands once each result is taken
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      div_num                 <= 23'h000000;
      div_r                   <= 17'h00000;
      div_q                   <= 23'h000000;
      div_cnt                 <= 5'h00;
      o_relative_charge_level <= 8'h00;
    end else if (div_cnt == 5'h00) begin
      div_num <= rem_x;
      div_r   <= 17'h00000;
      div_q   <= 23'h000000;
      div_cnt <= `EODRL_DIV_LEN;
    end else begin
      div_num <= {div_num[21:0], 1'b0};
      div_r   <= div_ge ? div_sh - {1'b0, learned_full_capacity} : div_sh;
      div_q   <= q_fin;
      div_cnt <= div_cnt - 5'h01;
      if (div_cnt == 5'h01) begin
        // a zero capacity or rounding excess reads as full
        if (q_fin > pct_full || learned_full_capacity == 16'h0000) begin
          o_relative_charge_level <= pct_full[7:0];
        end else begin
          o_relative_charge_level <= q_fin[7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // status word and alarm warning
  // ----------------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 16; b = b + 1) begin : g_stat
      if (b == `EODRL_BIT_EOD) begin : g_e
        assign o_batt_status[b] = discharge_end_alarm;
      end else if (b == `EODRL_BIT_RCAP) begin : g_c
        assign o_batt_status[b] = rem_cap_alarm;
      end else if (b == `EODRL_BIT_RTIM) begin : g_t
        assign o_batt_status[b] = rem_time_alarm;
      end else begin : g_z
        assign o_batt_status[b] = 1'b0;
      end
    end
  endgenerate

  assign o_alarm_warn = discharge_end_alarm | rem_cap_alarm | rem_time_alarm;
endmodule
`default_nettype wire

// >>> hdl/eodrl_regs.vh
// register map, field positions, reset values and constants for eodrl
`ifndef EODRL_REGS_VH
`define EODRL_REGS_VH
// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define EODRL_ADR_CTRL   8'h00
`define EODRL_ADR_STAT   8'h04
`define EODRL_ADR_THR    8'h08
`define EODRL_ADR_LFC    8'h0c
`define EODRL_ADR_MAXE   8'h10
`define EODRL_ADR_RCL    8'h14
`define EODRL_ADR_REM    8'h18
`define EODRL_ADR_ALM    8'h1c
`define EODRL_ADR_CFG_LO 8'h20
`define EODRL_ADR_CFG_HI 8'h74
// ----------------------------------------------------------------------
// byte indices inside the configuration array
// ----------------------------------------------------------------------
`define EODRL_CFG_TB     7'd0
`define EODRL_CFG_RB     7'd8
`define EODRL_CFG_PCT    7'd16
`define EODRL_CFG_TAB    7'd24
`define EODRL_CFG_N      88
// ----------------------------------------------------------------------
// status word bits
// ----------------------------------------------------------------------
`define EODRL_BIT_EOD    11
`define EODRL_BIT_RCAP   9
`define EODRL_BIT_RTIM   8
// ----------------------------------------------------------------------
// reset values and arithmetic constants
// ----------------------------------------------------------------------
`define EODRL_CONF_RST   8'h03
`define EODRL_RLIM_RST   8'hff
`define EODRL_BND_RST    8'hff
`define EODRL_PCT_RST    8'h00
`define EODRL_VEOD_RST   8'h4b
`define EODRL_LFC_RST    16'h0fa0
`define EODRL_VOLT_BASE  16'h1f40
`define EODRL_VOLT_STEP  16'h0004
`define EODRL_DIV10      16'h001a
`define EODRL_PCT_FULL   23'h000064
`define EODRL_DIV_LEN    5'h17
`endif

// >>> tb/eodrl_host.sv
// host model: classic bus master reading and writing the gauge
`timescale 1ns/10ps
`default_nettype none
module eodrl_host (
  // clock and slave answer
  input  wire logic        i_clk_sys,
  input  wire logic        i_ack,
  input  wire logic [31:0] i_dat,
  // request
  output var  logic        o_cyc,
  output var  logic        o_stb,
  output var  logic        o_we,
  output var  logic [7:0]  o_adr,
  output var  logic [3:0]  o_sel,
  output var  logic [31:0] o_dat
);
  initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
  // one cycle, held until ack is sampled; released data inverted so no stale match
  task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] s,
                      input logic [31:0] d, output logic [31:0] r);
    @(posedge i_clk_sys);
    {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} <= {2'b11, w, a, s, d};
    // only ack ends this wait; a hang is left to the bench timeout
    do begin
      @(posedge i_clk_sys);
    end while (i_ack !== 1'b1);
    r = i_dat;
    {o_cyc, o_stb, o_we, o_dat} <= {3'b000, ~d};
  endtask
endmodule
`default_nettype wire

// >>> tb/eodrl_sva.sv
// assertions on the ports of the end-of-discharge core
`timescale 1ns/10ps
`default_nettype none
module eodrl_sva (
  // clock and reset
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  // register bus
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic [31:0] o_wb_dat,
  input wire logic        o_wb_ack,
  // period tick and gauge results
  input wire logic        i_period_tick,
  input wire logic [15:0] o_batt_status,
  input wire logic        o_alarm_warn,
  input wire logic        o_eod_valid,
  input wire logic [15:0] o_full_cap,
  input wire logic [15:0] o_max_error,
  input wire logic [15:0] o_remaining_amount
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  // -----------------------------------------------------------------
  // bus timing
  // -----------------------------------------------------------------
  ack_one_cycle_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus answer late or held");
  dat_idle_zero_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h00000000)
    else $error("read data outside answer");
  // -----------------------------------------------------------------
  // end of discharge and its side effects
  // -----------------------------------------------------------------
  eod_after_tick_a: assert property (o_eod_valid |-> $past(i_period_tick))
    else $error("end of discharge without a period tick");
  eod_single_a: assert property (o_eod_valid |=> !o_eod_valid)
    else $error("end of discharge pulse too long");
  eod_alarm_set_a: assert property (o_eod_valid |-> o_batt_status[11] && o_alarm_warn)
    else $error("alarm missing at end of discharge");
  warn_is_or_a: assert property (o_alarm_warn == (|{o_batt_status[11], o_batt_status[9:8]}))
    else $error("warning does not follow alarm bits");
  err_cleared_a: assert property (o_eod_valid |-> o_max_error == 16'h0000)
    else $error("error not cleared");
  rem_zero_a: assert property (o_eod_valid |-> o_remaining_amount == 16'h0000)
    else $error("remaining not zero at end of discharge");
  cap_moment_a: assert property ($changed(o_full_cap) |-> o_eod_valid || $past(o_wb_ack))
    else $error("full capacity moved at a wrong moment");
  // main scenarios reached
  cover property (o_eod_valid);
  cover property (o_wb_ack && o_wb_dat != 32'h00000000);
  cover property ($changed(o_full_cap) && o_eod_valid);
  cover property (o_alarm_warn && !o_batt_status[11]);
endmodule
bind eodrl_core eodrl_sva u_eodrl_sva (.i_clk_sys, .i_reset, .i_wb_cyc, .i_wb_stb, .o_wb_dat,
  .o_wb_ack, .i_period_tick, .o_batt_status, .o_alarm_warn, .o_eod_valid, .o_full_cap,
  .o_max_error, .o_remaining_amount);
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the end-of-discharge core
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic i_clk_sys = 0, i_reset = 1, cyc, stb, we, ack, eod, warn, tick = 0, dis = 0;
  logic full_eoc = 0, partial = 0;
  logic [3:0] sel;
  logic [7:0] adr, temp_code = 8'h19, rate_code = 8'h05, rcl, tdeg = 8'h19;
  logic [15:0] pack_mv = 16'h2710, dis_cap = 16'h0064, err_inc = 16'h0005;
  logic [15:0] status, full_cap, max_err, rem;
  logic [31:0] wdat, rdat, err_total = 0, compares = 0, eod_cnt = 0, cycles = 0;
  eodrl_host u_host (.i_clk_sys, .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb),
    .o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat));
  eodrl_core u_eodrl_core (.i_clk_sys, .i_reset, .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_period_tick(tick), .i_pack_mv(pack_mv), .i_temp_code(temp_code), .i_temp_deg(tdeg),
    .i_rate_code(rate_code), .i_discharging(dis), .i_dis_cap(dis_cap), .i_err_inc(err_inc),
    .i_full_eoc(full_eoc), .i_partial_chg(partial), .o_batt_status(status),
    .o_alarm_warn(warn), .o_eod_valid(eod), .o_full_cap(full_cap), .o_max_error(max_err),
    .o_relative_charge_level(rcl), .o_remaining_amount(rem));
  always #10 i_clk_sys = ~i_clk_sys;
  // count pulses and cut a hang short
  always @(posedge i_clk_sys) begin
    if (eod === 1'b1) eod_cnt <= eod_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total++;
      finish_test;
    end
  end
  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    logic [31:0] r;
    u_host.xfer(1'b1, a, s, d, r);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    u_host.xfer(1'b0, a, 4'hf, 32'h0, r);
    check(r, e);
  endtask
  // ticks spaced well over the 24-cycle minimum
  task ticks(input int n);
    repeat (n) begin
      @(posedge i_clk_sys) tick <= 1;
      @(posedge i_clk_sys) tick <= 0;
      repeat (28) @(posedge i_clk_sys);
    end
  endtask
  task pulse_full(input bit part);
    @(posedge i_clk_sys) full_eoc <= 1;
    @(posedge i_clk_sys) full_eoc <= 0;
    partial <= part;
    @(posedge i_clk_sys) partial <= 0;
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task t_reset;
    check(full_cap, 32'h0fa0);
    rd_chk(8'h00, 32'h0000ff03);
    rd_chk(8'h78, 32'h0);
    wr(8'h04, 4'hf, 32'hffff);
    rd_chk(8'h04, 32'h0);
  endtask
  // bin choice, clamp and voltage decode
  task t_thresh;
    wr(8'h20, 4'hf, 32'h281e140a);
    wr(8'h24, 4'hf, 32'h50463c32);
    wr(8'h28, 4'hf, 32'h281e140a);
    wr(8'h2c, 4'hf, 32'h50463c32);
    wr(8'h38, 4'h4, 32'h00640000);
    ticks(1);
    rd_chk(8'h08, 32'h000220d0);
    temp_code <= 8'hc8;
    ticks(1);
    rd_chk(8'h08, 32'h0007206c);
    temp_code <= 8'h19;
  endtask
  // confirmed end of discharge with relearn
  task t_eod;
    wr(8'h00, 4'h1, 32'h02);
    pulse_full(0);
    pack_mv <= 16'h1f40;
    dis <= 1;
    ticks(1);
    check(eod_cnt, 0);
    ticks(1);
    check(eod_cnt, 1);
    check(status[11], 1);
    check(max_err, 0);
    check(rem, 0);
    check(full_cap, 32'h00c8);
    ticks(1);
    check(eod_cnt, 1);
    dis <= 0;
    ticks(1);
  endtask
  // partial charge, then rate over the limit: no relearn
  task t_no_relearn;
    dis_cap <= 16'h012c;
    for (int k = 0; k < 2; k++) begin
      if (k == 1) wr(8'h00, 4'h2, 32'h1000);
      if (k == 1) rate_code <= 8'h20;
      pulse_full(k == 0);
      dis <= 1;
      ticks(2);
      check(eod_cnt, 2 + k);
      if (k == 0) check(full_cap, 32'h00c8);
      else check(full_cap, 32'h00c8);
      dis <= 0;
      ticks(1);
    end
  endtask
  // cooling correction, warming hold, early alarms and charge level
  task t_temp;
    pack_mv <= 16'h2710;
    dis_cap <= 16'h0100;
    wr(8'h0c, 4'h3, 32'h8000);
    wr(8'h30, 4'hf, 32'h00004080);
    wr(8'h1c, 4'hf, 32'h04007d00);
    pulse_full(0);
    check(rem, 32'h8000);
    tdeg <= 8'h18;
    ticks(1);
    check(rem, 32'h7d00);
    tdeg <= 8'h19;
    dis <= 1;
    ticks(2);
    rd_chk(8'h18, 32'h02007c00);
    check({warn, status}, 32'h00010300);
    check(rcl, 32'h60);
    dis <= 0;
  endtask
  task finish_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_reset <= 0;
    t_reset;
    t_thresh;
    t_eod;
    t_no_relearn;
    t_temp;
    finish_test;
  end
endmodule
`default_nettype wire
